/* rtl/sram_port.sv */
// Purpose: Control and data path of a pipelined burst SRAM port with internal core.
//          Stage one holds the access taken, stage two its data phase.
//          Writes wait in a small buffer so the single core port serves reads first.
// Assumes: All pins synchronous to clk; two-way lanes split into in, out and enable.
//          The host keeps the burst strap fixed once reset is released.
//          The host leaves two non-read cycles after writes before reading them back.
// Notes: Output enable is sampled, so its effect lags one clock behind the pin.
//        A read of a word still in the buffer returns the older core contents.
//        A floating strap cannot be told from high; the reset value is interleaved.
`timescale 1ns/1ps
module sram_port import sram_port_pkg::*; #(
    parameter int LANES = BYTE_LANES,
    parameter int LBITS = LANE_BITS,
    parameter int AW = ADDR_BITS,
    parameter int WBUF_DEPTH = FIFO_DEPTH
) (
    // Clock, reset and clock qualifier
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_gate_n,
    // Selects and access control
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic [AW-1:0] addr,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic output_enable_n,
    input wire logic [LANES*LBITS-1:0] dq_in,
    output logic [LANES*LBITS-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [LANES-1:0] parity_lane_in,
    output logic [LANES-1:0] parity_lane_out,
    output logic parity_lane_oe_n,
    // Strap, buffer state and serial test path
    input wire logic burst_order_strap,
    output logic write_buffer_ready,
    input wire logic test_clk,
    input wire logic test_data_in,
    output logic test_data_out
);
    localparam int DW = LANES * LBITS;
    localparam int WORDS = 1 << AW;
    localparam int ENTRY_W = AW + LANES + DW + LANES;

    // Parameter checks; each refuses a shape the pipeline cannot serve
    initial begin
        if (AW < 2) begin
            $error("sram_port: AW must be at least 2 for the burst bits");
        end
        if (AW > 12) begin
            $error("sram_port: AW above 12 gives a core too large to hold");
        end
        if (LANES < 1) begin
            $error("sram_port: LANES must be at least 1");
        end
        if (LBITS < 1) begin
            $error("sram_port: LBITS must be at least 1");
        end
        if (WBUF_DEPTH < 2 || (WBUF_DEPTH & (WBUF_DEPTH - 1)) != 0) begin
            $error("sram_port: WBUF_DEPTH must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        // Burst order, caught once after reset
        logic interleave;
        logic strap_taken;
        // Stage one: access, address and burst position
        op_e op1;
        logic [AW-1:0] addr1;
        logic [1:0] base_low;
        logic [1:0] count;
        logic [LANES-1:0] be1_n;
        // Stage two: data phase of the access
        op_e op2;
        logic [AW-1:0] addr2;
        logic [LANES-1:0] be2_n;
        // Registered read word and drive enable
        logic rd_valid;
        logic [DW-1:0] rd_data;
        logic [LANES-1:0] rd_par;
        logic oe_n;
    } port_state_s;

    port_state_s state_ff;
    port_state_s nxt_state;

    // Memory core, one word per address plus one parity bit per lane
    logic [DW-1:0] core_data [WORDS];
    logic [LANES-1:0] core_par [WORDS];

    // One mask bit per data bit, set where the active-low lane select is low
    function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
        logic [DW-1:0] mask;
        mask = '0;
        for (int i = 0; i < LANES; i++) begin
            mask[i*LBITS +: LBITS] = {LBITS{~sel_n[i]}};
        end
        return mask;
    endfunction

    // Keeps unselected lanes, so a byte write leaves its neighbours alone
    function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0] old_word,
                                                  input logic [DW-1:0] new_word,
                                                  input logic [LANES-1:0] sel_n);
        logic [DW-1:0] mask;
        mask = lane_mask(sel_n);
        return (old_word & ~mask) | (new_word & mask);
    endfunction

    // Parity bits follow the select of their own lane
    function automatic logic [LANES-1:0] merge_par(input logic [LANES-1:0] old_par,
                                                   input logic [LANES-1:0] new_par,
                                                   input logic [LANES-1:0] sel_n);
        return (old_par & sel_n) | (new_par & ~sel_n);
    endfunction

    logic clk_en;
    logic selected;
    logic wbuf_in_valid;
    logic wbuf_in_ready;
    logic [ENTRY_W-1:0] wbuf_in_data;
    logic wbuf_out_valid;
    logic wbuf_out_ready;
    logic [ENTRY_W-1:0] wbuf_out_data;
    logic [AW-1:0] drain_addr;
    logic [LANES-1:0] drain_be_n;
    logic [DW-1:0] drain_data;
    logic [LANES-1:0] drain_par;
    logic drain_now;

    // Clock qualification: a high gate freezes both stages and the buffer, but not the strap, output enable or test flops
    assign clk_en = ~clock_gate_n;

    // Chip selection from the three sampled selects
    assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;

    // Write data captured in the data phase of a write into the buffer
    assign wbuf_in_valid = clk_en && (state_ff.op2 == OP_WRITE);
    assign wbuf_in_data = {state_ff.addr2, state_ff.be2_n, dq_in, parity_lane_in};

    // Core drains the buffer only when no read owns the single core port
    assign wbuf_out_ready = clk_en && (state_ff.op1 != OP_READ);
    assign drain_now = wbuf_out_valid & wbuf_out_ready;
    assign {drain_addr, drain_be_n, drain_data, drain_par} = wbuf_out_data;

    sram_write_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .clk(clk),
        .nrst(nrst),
        .in_valid(wbuf_in_valid),
        .in_ready(wbuf_in_ready),
        .in_data(wbuf_in_data),
        .out_valid(wbuf_out_valid),
        .out_ready(wbuf_out_ready),
        .out_data(wbuf_out_data)
    );

    sram_test_serial #(
        .LEN(TEST_CHAIN_LEN)
    ) u_test (
        .clk(clk),
        .nrst(nrst),
        .test_clk(test_clk),
        .test_data_in(test_data_in),
        .test_data_out(test_data_out)
    );

    // Host watches this to avoid overrunning the write buffer
    assign write_buffer_ready = wbuf_in_ready;

    assign dq_out = state_ff.rd_data;
    assign parity_lane_out = state_ff.rd_par;
    assign dq_oe_n = state_ff.oe_n;
    assign parity_lane_oe_n = state_ff.oe_n;

    // Next-state logic for the address and control pipeline
    // Read: taken at c0; at c1 the core word lands in the output flops
    // and the drive opens if output enable was low before c1.
    // Write: taken at c0; lanes stay released through c1 for the host,
    // captured into the buffer at c2, written to the core when no read holds stage one.
    // A high clock gate freezes both stages, so a stalled cycle simply repeats.
    always_comb begin
        nxt_state = state_ff;

        // Strap caught once after reset release; held afterwards as it must not move
        if (!state_ff.strap_taken) begin
            nxt_state.interleave = burst_order_strap;
            nxt_state.strap_taken = 1'b1;
        end

        if (clk_en) begin
            // Stage two follows stage one on every qualified edge
            nxt_state.op2 = state_ff.op1;
            nxt_state.addr2 = state_ff.addr1;
            nxt_state.be2_n = state_ff.be1_n;

            if (!selected) begin
                nxt_state.op1 = OP_IDLE;
                nxt_state.count = BURST_START;
            end else if (!advance_or_load) begin
                // New access: read when write strobe is high
                nxt_state.op1 = write_n ? OP_READ : OP_WRITE;
                nxt_state.addr1 = addr;
                nxt_state.base_low = addr[1:0];
                nxt_state.count = BURST_START;
            end else if (state_ff.op1 != OP_IDLE) begin
                // Burst step on the two low address bits, wrapping after four
                nxt_state.count = state_ff.count + BURST_STEP;
                nxt_state.addr1[1:0] = burst_low(state_ff.base_low, nxt_state.count,
                                                 state_ff.interleave);
            end
            // Advance after a deselect keeps the port idle until a load

            // Byte selects count only when the write strobe is low
            nxt_state.be1_n = write_n ? {LANES{1'b1}} : byte_lane_write_n;

            // Read data registered one qualified edge after its address
            nxt_state.rd_valid = (state_ff.op1 == OP_READ);
            if (state_ff.op1 == OP_READ) begin
                // Core word of the address held in stage one
                nxt_state.rd_data = core_data[state_ff.addr1];
                nxt_state.rd_par = core_par[state_ff.addr1];
            end
        end

        // Output enable is sampled on every clock edge, so it is not gated by the clock gate
        nxt_state.oe_n = ~(nxt_state.rd_valid & ~output_enable_n);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '{
                interleave: STRAP_RESET,
                strap_taken: 1'b0,
                op1: OP_IDLE,
                addr1: '0,
                base_low: BURST_START,
                count: BURST_START,
                be1_n: '1,
                op2: OP_IDLE,
                addr2: '0,
                be2_n: '1,
                rd_valid: 1'b0,
                rd_data: '0,
                rd_par: '0,
                oe_n: OE_OFF_N
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Core write port; each lane and its parity bit follow that lane's select
    always_ff @(posedge clk) begin
        if (drain_now) begin
            core_data[drain_addr] <= merge_lanes(core_data[drain_addr], drain_data, drain_be_n);
            core_par[drain_addr] <= merge_par(core_par[drain_addr], drain_par, drain_be_n);
        end
    end

endmodule

/* rtl/sram_port_pkg.sv */
// Purpose: Shared constants, types and burst arithmetic for the pipelined SRAM port.
// Assumes: One 25 MHz clock; all pins sampled synchronously to it.
package sram_port_pkg;

    localparam int BYTE_LANES = 4;
    localparam int LANE_BITS = 8;
    localparam int ADDR_BITS = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int TEST_CHAIN_LEN = 8;

    localparam logic STRAP_RESET = 1'h1;
    localparam logic [1:0] BURST_START = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic OE_OFF_N = 1'h1;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } op_e;

    // Low two address bits of a burst beat; both orders wrap after four beats
    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] count,
                                             input logic interleave);
        logic [1:0] sum;
        sum = base + count;
        burst_low = interleave ? (base ^ count) : sum;
    endfunction

endpackage

/* rtl/sram_test_serial.sv */
// Purpose: Serial test data path between test data in and test data out.
// Assumes: Test clock is a pin sampled on clk, at most a quarter of its rate.
// Notes: Plain shift chain; no test access state machine.
`timescale 1ns/1ps
module sram_test_serial import sram_port_pkg::*; #(
    parameter int LEN = TEST_CHAIN_LEN
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic test_clk,
    input wire logic test_data_in,
    output logic test_data_out
);
    initial begin
        if (LEN < 2) begin
            $error("sram_test_serial: LEN must be at least 2");
        end
    end

    typedef struct packed {
        logic tck_prev;
        logic [LEN-1:0] chain;
        logic tdo;
    } test_state_s;

    test_state_s state_ff;
    test_state_s nxt_state;

    assign test_data_out = state_ff.tdo;

    // Edges found from the sampled test clock
    always_comb begin
        nxt_state = state_ff;
        nxt_state.tck_prev = test_clk;
        if (test_clk && !state_ff.tck_prev) begin
            nxt_state.chain = {test_data_in, state_ff.chain[LEN-1:1]};
        end
        if (!test_clk && state_ff.tck_prev) begin
            nxt_state.tdo = state_ff.chain[0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '{tck_prev: 1'b0, chain: '0, tdo: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule

/* rtl/sram_write_fifo.sv */
// Purpose: Buffer between captured write data and the memory core write port.
// Assumes: Single clock; push and pop already qualified by the caller.
// Notes: Ready comes straight from its own flop; valid is the inverse of the empty flop.
`timescale 1ns/1ps
module sram_write_fifo import sram_port_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("sram_write_fifo: DEPTH must be a power of two >= 2");
        end
    end

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic full;
        logic not_full;
        logic empty;
    } fifo_state_s;

    fifo_state_s state_ff;
    fifo_state_s nxt_state;
    logic [WIDTH-1:0] store [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid & ~state_ff.full;
    assign pop = out_ready & ~state_ff.empty;
    assign in_ready = state_ff.not_full; // Own flop, so the port's ready pin needs no gate
    assign out_valid = ~state_ff.empty;
    assign out_data = store[state_ff.rd_ptr];

    // Pointer and occupancy update
    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
        end
        nxt_state.count = state_ff.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        nxt_state.full = (nxt_state.count == (PW+1)'(DEPTH));
        nxt_state.not_full = ~nxt_state.full;
        nxt_state.empty = (nxt_state.count == '0);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '{wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, not_full: 1'b1, empty: 1'b1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Storage has no reset; empty flag guards stale words
    always_ff @(posedge clk) begin
        if (push) begin
            store[state_ff.wr_ptr] <= in_data;
        end
    end

endmodule

/* verification/host_bus_model.sv */
// Purpose: Host side of the two-way data and parity lanes.
// Assumes: Host drives only in the data phase of its own writes.
// Notes: Undriven lanes show the inverse of the last value seen.
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clk,
    input wire logic host_en,
    input wire logic [35:0] host_word,
    input wire logic dq_oe_n,
    input wire logic [31:0] dq_out,
    input wire logic [3:0] parity_lane_out,
    output logic [31:0] dq_in,
    output logic [3:0] parity_lane_in
);
    logic [35:0] last_ff;
    // Resolve the lanes; a floating bus must never look like fresh data
    always_comb begin
        if (host_en) {parity_lane_in, dq_in} = host_word;
        else if (!dq_oe_n) {parity_lane_in, dq_in} = {parity_lane_out, dq_out};
        else {parity_lane_in, dq_in} = ~last_ff;
    end
    always_ff @(posedge clk) last_ff <= {parity_lane_in, dq_in};
endmodule

/* verification/pipelined_sram_port_control_tb_top.sv */
// Purpose: Self-checking bench for the pipelined SRAM port.
// Assumes: Strap moves only while reset is held.
// Notes: Reads are noted in a queue, popped when driven data appears.
`timescale 1ns/1ps
module pipelined_sram_port_control_tb_top;
    import sram_port_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, clock_gate_n = 1'h0, chip_select_first_n = 1'h1, chip_select_second = 1'h0;
    logic chip_select_third_n = 1'h1, advance_or_load = 1'h0, write_n = 1'h1, output_enable_n = 1'h0;
    logic burst_order_strap = 1'h1, test_clk = 1'h0, test_data_in = 1'h0, host_en = 1'h0, qe = 1'h0;
    logic dq_oe_n, parity_lane_oe_n, write_buffer_ready, test_data_out;
    logic [9:0] addr = 10'h000;
    logic [3:0] byte_lane_write_n = 4'hF, parity_lane_in, parity_lane_out;
    logic [31:0] dq_in, dq_out, lfsr = 32'hA93B59BD;
    logic [35:0] host_word = 36'h0, ref_mem [0:1023], exp_q [$];
    logic [36:0] p1 = 37'h0, p2 = 37'h0;
    int failures = 0, checked = 0;
    logic ser_last = 1'h0;
    sram_port uut (.clk, .nrst, .clock_gate_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
        .advance_or_load, .write_n, .addr, .byte_lane_write_n, .output_enable_n, .dq_in, .dq_out, .dq_oe_n,
        .parity_lane_in, .parity_lane_out, .parity_lane_oe_n, .burst_order_strap, .write_buffer_ready,
        .test_clk, .test_data_in, .test_data_out);
    host_bus_model host (.clk, .host_en, .host_word, .dq_oe_n, .dq_out, .parity_lane_out, .dq_in, .parity_lane_in);
    always #20 clk = ~clk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %0t bit %b want %b", $time, got, exp);
        end
    endtask
    // One host cycle; write data goes out two cycles after its request
    task automatic step(input logic sel, input logic wr, input logic adv, input logic [9:0] a,
                        input logic [3:0] bw, input logic [35:0] wd, input logic note);
        @(posedge clk);
        {chip_select_first_n, chip_select_second, chip_select_third_n} <= {!sel, sel, !sel};
        {clock_gate_n, write_n, advance_or_load, addr, byte_lane_write_n} <= {1'h0, !wr, adv, a, bw};
        {host_en, host_word} <= p2;
        p2 = p1;
        p1 = {sel & wr, wd};
        for (int i = 0; i < 4; i++) if (sel && wr && !bw[i]) ref_mem[a][8*i +: 8] = wd[8*i +: 8];
        for (int i = 0; i < 4; i++) if (sel && wr && !bw[i]) ref_mem[a][32+i] = wd[32+i];
        if (note) exp_q.push_back(ref_mem[a]);
    endtask
    task automatic idle();
        step(1'h0, 1'h0, 1'h0, 10'h000, 4'hF, 36'h0, 1'h0);
    endtask
    // One test clock period of five clocks; output may move only after the fall
    task automatic serial_bit(input logic d, input logic want);
        @(posedge clk);
        {test_clk, test_data_in} <= {1'h1, d};
        repeat (2) @(posedge clk);
        check_bit(test_data_out, ser_last);
        test_clk <= 1'h0;
        repeat (2) @(posedge clk);
        check_bit(test_data_out, want);
        ser_last = want;
    endtask
    // Read, write, burst, stall and refusal traffic for one strap level
    task automatic traffic(input logic il);
        logic [9:0] a [8];
        logic [31:0] r;
        logic [1:0] lo;
        logic [7:0] hi;
        logic [15:0] sd;
        r = rnd();
        hi = r[9:2];
        for (int i = 0; i < 16; i++) begin
            if (i < 8) a[i] = (i < 4) ? {hi, 2'(i)} : 10'(rnd());
            r = rnd();
            step(1'h1, 1'h1, 1'h0, a[i%8], i < 8 ? 4'h0 : r[3:0], {r[7:4], rnd()}, 1'h0);
        end
        repeat (4) idle();
        for (int i = 0; i < 8; i++) step(1'h1, 1'h0, 1'h0, a[i], 4'hF, 36'h0, 1'h1);
        for (int k = 0; k < 5; k++) begin
            lo = il ? (a[2][1:0] ^ 2'(k)) : (a[2][1:0] + 2'(k));
            step(1'h1, 1'h0, k > 0, {a[2][9:2], lo}, 4'hF, 36'h0, 1'h1);
        end
        step(1'h1, 1'h0, 1'h0, a[5], 4'hF, 36'h0, 1'h1);
        @(posedge clk);
        clock_gate_n <= 1'h1;
        repeat (2) @(posedge clk);
        idle();
        idle();
        step(1'h1, 1'h0, 1'h1, a[6], 4'hF, 36'h0, 1'h0);
        idle();
        output_enable_n <= 1'h1;
        step(1'h1, 1'h0, 1'h0, a[7], 4'hF, 36'h0, 1'h0);
        idle();
        idle(); // Read taken with enable high drains before the pin is lowered
        output_enable_n <= 1'h0;
        repeat (3) idle();
        check_bit(write_buffer_ready, 1'h1);
        ser_last = 1'h0;
        sd = 16'(rnd());
        for (int k = 0; k < 16; k++) begin
            serial_bit(sd[k], k >= TEST_CHAIN_LEN - 1 ? sd[k - TEST_CHAIN_LEN + 1] : 1'h0);
        end
    endtask
    // Monitor: a qualified edge with the lanes driven carries one read word
    always @(posedge clk) qe = !clock_gate_n && nrst;
    always @(negedge clk) begin
        if (qe && dq_oe_n === 1'h0) begin
            if (exp_q.size() == 0) check_word({parity_lane_out, dq_out}, 36'hX);
            else check_word({parity_lane_out, dq_out}, exp_q.pop_front());
        end
    end
    task automatic wrap_up();
        if (exp_q.size() != 0) begin
            failures++;
            $display("unexpected %0t %0d reads never driven", $time, exp_q.size());
        end
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the traffic needs
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    // Strap changes only while reset is held
    initial begin
        for (int s = 1; s >= 0; s--) begin
            nrst <= 1'h0;
            burst_order_strap <= s[0];
            repeat (3) @(posedge clk);
            nrst <= 1'h1;
            traffic(s[0]);
        end
        wrap_up();
    end
endmodule

/* verification/sram_port_properties.sv */
// Purpose: Temporal checks on the pins of the SRAM port.
// Assumes: Output enable acts one clock late, as the port samples it.
// Notes: Bound to every instance of the port.
`timescale 1ns/1ps
module sram_port_checker #(
    parameter int LANES = 4,
    parameter int LBITS = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_gate_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic [LANES*LBITS-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic [LANES-1:0] parity_lane_out,
    input wire logic parity_lane_oe_n,
    input wire logic test_clk,
    input wire logic test_data_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic sel;
    logic go;
    // Selection and a new access on a qualified edge
    assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    assign go = !clock_gate_n && sel && !advance_or_load;
    property p_gate_hold;
        clock_gate_n |=> $stable(dq_out) && $stable(parity_lane_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated edge moved data");
    property p_gate_keep;
        clock_gate_n && !output_enable_n && !dq_oe_n |=> !dq_oe_n;
    endproperty
    a_gate_keep: assert property (p_gate_keep) else $error("gate deselected");
    property p_oe_off;
        output_enable_n |=> dq_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driving with enable high");
    property p_deselect;
        (!clock_gate_n && !sel) ##1 !clock_gate_n |=> dq_oe_n;
    endproperty
    a_deselect: assert property (p_deselect) else $error("driving while deselected");
    property p_write_tri;
        (go && !write_n) ##1 !clock_gate_n |=> dq_oe_n;
    endproperty
    a_write_tri: assert property (p_write_tri) else $error("driving in write data");
    property p_read_drive;
        (go && write_n) ##1 (!clock_gate_n && !output_enable_n) |=> !dq_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    property p_parity_oe;
        parity_lane_oe_n == dq_oe_n;
    endproperty
    a_parity_oe: assert property (p_parity_oe) else $error("parity drive differs");
    property p_serial;
        $changed(test_data_out) |-> !test_clk;
    endproperty
    a_serial: assert property (p_serial) else $error("serial out moved early");
    // Main traffic kinds
    c_read: cover property (go && write_n ##2 !dq_oe_n);
    c_stall: cover property (clock_gate_n [*3]);
    c_burst: cover property (!clock_gate_n && sel && advance_or_load);
endmodule
bind sram_port sram_port_checker #(.LANES(LANES), .LBITS(LBITS)) u_chk (
    .clk, .nrst, .clock_gate_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
    .advance_or_load, .write_n, .output_enable_n, .dq_out, .dq_oe_n, .parity_lane_out,
    .parity_lane_oe_n, .test_clk, .test_data_out
);
